/* pkg/i2c_hold_pkg.sv */
// Package with constants and types shared by the two-wire slave hold/transmit engine.
package i2c_hold_pkg;
  // ==========================================================================
  // Byte framing
  localparam int          BitsPerByte  = 8;
  localparam logic [3:0]  AckBitIndex  = 4'h9;
  localparam logic [3:0]  LastDataBit  = 4'h8;
  localparam logic [4:0]  TenBitPrefix = 5'h1E;
  localparam logic [7:0]  ResetByte    = 8'h00;
  localparam logic [9:0]  ResetAddress = 10'h000;

  // ==========================================================================
  // Slave sequencer states
  typedef enum logic [2:0] {
    StIdle,
    StAddr,
    StRxData,
    StTxData,
    StAckOut,
    StAckIn
  } slave_state_e;
endpackage

/* pkg/i2c_line_if.sv */
// Interface carrying the sampled bus lines and condition events between design modules.
`timescale 1ns/1ps
interface i2c_line_if;
  logic sclLevel;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  modport producer (
    output sclLevel,
    output sdaLevel,
    output sclRise,
    output sclFall,
    output startSeen,
    output stopSeen
  );
  modport consumer (
    input sclLevel,
    input sdaLevel,
    input sclRise,
    input sclFall,
    input startSeen,
    input stopSeen
  );
endinterface

/* logic/i2c_line_sampler.sv */
// Bus line synchroniser with clock edge and start/stop condition detection.
`timescale 1ns/1ps
module i2c_line_sampler (
  input  wire logic mclk,
  input  wire logic rstSync_n,
  input  wire logic clkEn,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  i2c_line_if.producer lines
);
  // ==========================================================================
  // Two-stage synchronisers; stage one is read by stage two only.
  logic [1:0] sclMeta_q, sclMeta_d;
  logic [1:0] sdaMeta_q, sdaMeta_d;
  logic       sclPrev_q, sclPrev_d;
  logic       sdaPrev_q, sdaPrev_d;

  always_comb begin
    sclMeta_d = sclMeta_q;
    sdaMeta_d = sdaMeta_q;
    sclPrev_d = sclPrev_q;
    sdaPrev_d = sdaPrev_q;
    if (clkEn) begin
      sclMeta_d = {sclMeta_q[0], sclIn};
      sdaMeta_d = {sdaMeta_q[0], sdaIn};
      sclPrev_d = sclMeta_q[1];
      sdaPrev_d = sdaMeta_q[1];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sclMeta_q <= 2'h3;
      sdaMeta_q <= 2'h3;
      sclPrev_q <= 1'h1;
      sdaPrev_q <= 1'h1;
    end else begin
      sclMeta_q <= sclMeta_d;
      sdaMeta_q <= sdaMeta_d;
      sclPrev_q <= sclPrev_d;
      sdaPrev_q <= sdaPrev_d;
    end
  end

  assign lines.sclLevel  = sclMeta_q[1];
  assign lines.sdaLevel  = sdaMeta_q[1];
  assign lines.sclRise   = clkEn && sclMeta_q[1] && !sclPrev_q;
  assign lines.sclFall   = clkEn && !sclMeta_q[1] && sclPrev_q;
  assign lines.startSeen = clkEn && sclMeta_q[1] && sclPrev_q && !sdaMeta_q[1] && sdaPrev_q;
  assign lines.stopSeen  = clkEn && sclMeta_q[1] && sclPrev_q && sdaMeta_q[1] && !sdaPrev_q;
endmodule

/* logic/i2c_slave_hold_transmit_engine.sv */
// Two-wire slave engine with address/data hold, transmission, and 10-bit addressing.
`timescale 1ns/1ps
module i2c_slave_hold_transmit_engine (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       tenBitMode,
  input  wire logic       addressHoldEnable,
  input  wire logic       dataHoldEnable,
  input  wire logic       stretchEnable,
  input  wire logic       slaveCollisionDetectEnable,
  input  wire logic       ackValueSelect,
  input  wire logic [9:0] slaveAddressWr,
  input  wire logic       slaveAddressWe,
  input  wire logic [7:0] bufferWrData,
  input  wire logic       bufferWe,
  input  wire logic       bufferRe,
  output logic [7:0]      rxTxBuffer,
  input  wire logic       setClockRelease,
  input  wire logic       clearIrqFlag,
  input  wire logic       clearCollisionFlag,
  input  wire logic       clearOverflowFlag,
  output logic            serialPortIrqFlag,
  output logic            clockReleaseBit,
  output logic            ackTimeFlag,
  output logic            bufferFullFlag,
  output logic            receiveOverflowFlag,
  output logic            ackReceivedStatus,
  output logic            readWriteStatus,
  output logic            updateAddressFlag,
  output logic            stopSeenFlag,
  output logic            busCollisionFlag,
  output logic [9:0]      slaveAddressReg
);
  // ==========================================================================
  // Reset release and line sampling
  logic [1:0] rstPipe_q;
  logic       rstSync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'h1};
    end
  end
  assign rstSync_n = rstPipe_q[1];

  i2c_line_if lines ();
  i2c_line_sampler u_sampler (
    .mclk      (mclk),
    .rstSync_n (rstSync_n),
    .clkEn     (clkEn),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .lines     (lines)
  );

  // ==========================================================================
  // Address compare helpers
  function automatic logic highMatch(input logic [7:0] b, input logic [9:0] a);
    highMatch = (b[7:3] == i2c_hold_pkg::TenBitPrefix) && (b[2:1] == a[9:8]);
  endfunction

  function automatic logic sevenMatch(input logic [7:0] b, input logic [9:0] a);
    sevenMatch = (b[7:1] == a[7:1]);
  endfunction

  // ==========================================================================
  // State
  i2c_hold_pkg::slave_state_e st_q, st_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] buf_q, buf_d;
  logic [9:0] addr_q, addr_d;
  logic       irq_q, irq_d, ckp_q, ckp_d, ack_time_flag_q, ack_time_flag_d, bf_q, bf_d;
  logic       ov_q, ov_d, ack_received_status_q, ack_received_status_d, rw_q, rw_d, ua_q, ua_d;
  logic       stop_q, stop_d, bcl_q, bcl_d;
  logic       isAddr_q, isAddr_d, holdPend_q, holdPend_d, sendAck_q, sendAck_d;
  logic       lowPhase_q, lowPhase_d, hiMatched_q, hiMatched_d;
  logic       sdaLow_q, sdaLow_d, sclHold_q, sclHold_d;
  logic [7:0] rxByte;
  logic       addrMatch;

  assign rxByte = {shift_q[6:0], lines.sdaLevel};

  always_comb begin
    st_d = st_q; shift_d = shift_q; bitCnt_d = bitCnt_q; buf_d = buf_q;
    addr_d = addr_q; irq_d = irq_q; ckp_d = ckp_q; ack_time_flag_d = ack_time_flag_q;
    bf_d = bf_q; ov_d = ov_q; ack_received_status_d = ack_received_status_q; rw_d = rw_q; ua_d = ua_q;
    stop_d = stop_q; bcl_d = bcl_q; isAddr_d = isAddr_q; holdPend_d = holdPend_q;
    sendAck_d = sendAck_q; lowPhase_d = lowPhase_q; hiMatched_d = hiMatched_q;
    sdaLow_d = sdaLow_q; sclHold_d = sclHold_q;
    addrMatch = 1'h0;
    if (clkEn) begin
      // Software side effects first so that hardware sets below win over clears.
      if (clearIrqFlag) irq_d = 1'h0;
      if (clearCollisionFlag) bcl_d = 1'h0;
      if (clearOverflowFlag) ov_d = 1'h0;
      if (setClockRelease) ckp_d = 1'h1;
      if (bufferRe) bf_d = 1'h0;
      if (bufferWe) begin
        buf_d = bufferWrData;
        shift_d = bufferWrData;
        bf_d = 1'h1;
      end
      if (slaveAddressWe) begin
        addr_d = slaveAddressWr;
        ua_d = 1'h0;
      end
      if (lines.startSeen) begin
        st_d = i2c_hold_pkg::StAddr; bitCnt_d = 4'h0; isAddr_d = 1'h1;
        sdaLow_d = 1'h0; stop_d = 1'h0; ack_time_flag_d = 1'h0;
        lowPhase_d = 1'h0;
      end else if (lines.stopSeen) begin
        st_d = i2c_hold_pkg::StIdle; stop_d = 1'h1;
        sdaLow_d = 1'h0; hiMatched_d = 1'h0;
      end else begin
        case (st_q)
          i2c_hold_pkg::StAddr, i2c_hold_pkg::StRxData: begin
            if (lines.sclRise) begin
              shift_d = rxByte;
              bitCnt_d = bitCnt_q + 4'h1;
            end
            if (lines.sclFall && bitCnt_q == i2c_hold_pkg::LastDataBit) begin
              if (st_q == i2c_hold_pkg::StAddr) begin
                if (!tenBitMode) addrMatch = sevenMatch(shift_q, addr_q);
                else if (lowPhase_q) addrMatch = (shift_q == addr_q[7:0]);
                else addrMatch = highMatch(shift_q, addr_q);
                if (tenBitMode && lowPhase_q) begin
                  irq_d = 1'h1; ua_d = 1'h1;
                  sendAck_d = addrMatch;
                  hiMatched_d = addrMatch;
                  if (addrMatch) begin
                    buf_d = shift_q; bf_d = 1'h1;
                  end
                  st_d = i2c_hold_pkg::StAckOut;
                end else if (!addrMatch || (tenBitMode && shift_q[0] && !hiMatched_q)) begin
                  st_d = i2c_hold_pkg::StIdle;
                end else begin
                  sendAck_d = !(bf_q || ov_q);
                  if (bf_q) ov_d = 1'h1;
                  rw_d = shift_q[0];
                  buf_d = shift_q;
                  bf_d = 1'h1;
                  if (tenBitMode && !shift_q[0]) ua_d = 1'h1;
                  if (addressHoldEnable) begin
                    irq_d = 1'h1; ckp_d = 1'h0; ack_time_flag_d = 1'h1;
                    holdPend_d = 1'h1;
                  end
                  st_d = i2c_hold_pkg::StAckOut;
                end
              end else begin
                sendAck_d = !(bf_q || ov_q);
                if (bf_q) ov_d = 1'h1;
                else begin
                  buf_d = shift_q; bf_d = 1'h1;
                end
                if (dataHoldEnable) begin
                  irq_d = 1'h1; ckp_d = 1'h0; ack_time_flag_d = 1'h1;
                  holdPend_d = 1'h1;
                end
                st_d = i2c_hold_pkg::StAckOut;
              end
            end
          end
          i2c_hold_pkg::StAckOut: begin
            // In hold modes the ack slot waits for release and takes the software choice.
            if (holdPend_q && ckp_q) begin
              holdPend_d = 1'h0;
              sendAck_d = !ackValueSelect;
            end
            if (!holdPend_q && !lines.sclLevel) sdaLow_d = sendAck_q;
            if (lines.sclFall && !holdPend_q && sdaLow_q == sendAck_q && lines.sclLevel == 1'h0) begin
              sdaLow_d = 1'h0;
            end
            if (lines.sclFall && !holdPend_q) begin
              ack_time_flag_d = 1'h0;
              bitCnt_d = 4'h0;
              if (!sendAck_q) begin
                st_d = i2c_hold_pkg::StIdle;
              end else begin
                irq_d = 1'h1;
                if (isAddr_q && tenBitMode && ua_q) begin
                  lowPhase_d = !lowPhase_q;
                  st_d = lowPhase_q ? i2c_hold_pkg::StRxData : i2c_hold_pkg::StAddr;
                  isAddr_d = !lowPhase_q ? 1'h1 : 1'h0;
                  if (!hiMatched_q && lowPhase_q) st_d = i2c_hold_pkg::StIdle;
                end else if (rw_q) begin
                  ckp_d = 1'h0;
                  st_d = i2c_hold_pkg::StTxData;
                  shift_d = buf_q;
                end else begin
                  if (stretchEnable) ckp_d = 1'h0;
                  isAddr_d = 1'h0;
                  st_d = i2c_hold_pkg::StRxData;
                end
              end
            end
          end
          i2c_hold_pkg::StTxData: begin
            if (ckp_q && !lines.sclLevel && bitCnt_q == 4'h0) begin
              sdaLow_d = !shift_q[7];
            end
            if (lines.sclRise) begin
              if (slaveCollisionDetectEnable && !sdaLow_q && !lines.sdaLevel) begin
                bcl_d = 1'h1;
                sdaLow_d = 1'h0;
                st_d = i2c_hold_pkg::StIdle;
              end
              bitCnt_d = bitCnt_q + 4'h1;
            end
            if (lines.sclFall && bitCnt_q != 4'h0) begin
              shift_d = {shift_q[6:0], 1'h0};
              if (bitCnt_q == i2c_hold_pkg::LastDataBit) begin
                sdaLow_d = 1'h0;
                st_d = i2c_hold_pkg::StAckIn;
              end else begin
                sdaLow_d = !shift_q[6];
              end
            end
          end
          i2c_hold_pkg::StAckIn: begin
            if (lines.sclRise) begin
              ack_received_status_d = lines.sdaLevel;
              bitCnt_d = i2c_hold_pkg::AckBitIndex;
            end
            if (lines.sclFall && bitCnt_q == i2c_hold_pkg::AckBitIndex) begin
              irq_d = 1'h1;
              bitCnt_d = 4'h0;
              bf_d = 1'h0;
              if (ack_received_status_q) begin
                st_d = i2c_hold_pkg::StIdle;
              end else begin
                ckp_d = 1'h0;
                st_d = i2c_hold_pkg::StTxData;
              end
            end
          end
          default: st_d = i2c_hold_pkg::StIdle;
        endcase
      end
      // Hold only once the master already pulled the clock low.
      // A pending address update stretches once the ack slot is over, not during it.
      sclHold_d = (!ckp_d || (ua_d && tenBitMode && st_d != i2c_hold_pkg::StAckOut))
                  && (sclHold_q || !lines.sclLevel);
      if (st_d == i2c_hold_pkg::StIdle) sclHold_d = 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_q <= i2c_hold_pkg::StIdle; shift_q <= i2c_hold_pkg::ResetByte;
      bitCnt_q <= 4'h0; buf_q <= i2c_hold_pkg::ResetByte;
      addr_q <= i2c_hold_pkg::ResetAddress; irq_q <= 1'h0; ckp_q <= 1'h1;
      ack_time_flag_q <= 1'h0; bf_q <= 1'h0; ov_q <= 1'h0; ack_received_status_q <= 1'h0;
      rw_q <= 1'h0; ua_q <= 1'h0; stop_q <= 1'h0; bcl_q <= 1'h0;
      isAddr_q <= 1'h0; holdPend_q <= 1'h0; sendAck_q <= 1'h0;
      lowPhase_q <= 1'h0; hiMatched_q <= 1'h0; sdaLow_q <= 1'h0; sclHold_q <= 1'h0;
    end else begin
      st_q <= st_d; shift_q <= shift_d; bitCnt_q <= bitCnt_d; buf_q <= buf_d;
      addr_q <= addr_d; irq_q <= irq_d; ckp_q <= ckp_d; ack_time_flag_q <= ack_time_flag_d;
      bf_q <= bf_d; ov_q <= ov_d; ack_received_status_q <= ack_received_status_d; rw_q <= rw_d; ua_q <= ua_d;
      stop_q <= stop_d; bcl_q <= bcl_d; isAddr_q <= isAddr_d; holdPend_q <= holdPend_d;
      sendAck_q <= sendAck_d; lowPhase_q <= lowPhase_d; hiMatched_q <= hiMatched_d;
      sdaLow_q <= sdaLow_d; sclHold_q <= sclHold_d;
    end
  end

  // ==========================================================================
  // Pins and status; open-drain lines only ever pull low.
  assign sclOut              = 1'h0;
  assign sclOe               = sclHold_q;
  assign sdaOut              = 1'h0;
  assign sdaOe               = sdaLow_q;
  assign rxTxBuffer          = buf_q;
  assign serialPortIrqFlag   = irq_q;
  assign clockReleaseBit     = ckp_q;
  assign ackTimeFlag         = ack_time_flag_q;
  assign bufferFullFlag      = bf_q;
  assign receiveOverflowFlag = ov_q;
  assign ackReceivedStatus   = ack_received_status_q;
  assign readWriteStatus     = rw_q;
  assign updateAddressFlag   = ua_q;
  assign stopSeenFlag        = stop_q;
  assign busCollisionFlag    = bcl_q;
  assign slaveAddressReg     = addr_q;
endmodule

/* verif/i2c_master_model.sv */
// Behavioural bus master that drives the clock and the start and stop conditions.
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic mclk,
  input  wire logic sclBus,
  input  wire logic sdaBus,
  output logic      sclLow,
  output logic      sdaLow
);
  // ==========================================================================
  // Bus phases
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic quarter();
    repeat (8) @(posedge mclk);
  endtask
  // A slave may stretch, so the high phase starts once the line reads high, or after at most 4000 cycles of waiting.
  task automatic sclHigh();
    sclLow <= 1'b0;
    for (int i = 0; i < 4000 && !sclBus; i++) @(posedge mclk);
    quarter();
  endtask
  task automatic start();
    sdaLow <= 1'b1;
    quarter();
    sclLow <= 1'b1;
    quarter();
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    quarter();
    sclHigh();
    sdaLow <= 1'b0;
    quarter();
  endtask
  task automatic bitIo(input logic b, output logic s);
    sdaLow <= ~b;
    quarter();
    sclHigh();
    s = sdaBus;
    quarter();
    sclLow <= 1'b1;
    quarter();
  endtask
endmodule

/* verif/i2c_engine_chk.sv */
// Port checker for the two-wire slave engine, bound to its top module.
`timescale 1ns/1ps
module i2c_engine_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic bufferRe,
  input wire logic setClockRelease,
  input wire logic slaveAddressWe,
  input wire logic serialPortIrqFlag,
  input wire logic clockReleaseBit,
  input wire logic bufferFullFlag,
  input wire logic ackReceivedStatus,
  input wire logic updateAddressFlag,
  input wire logic stopSeenFlag,
  input wire logic busCollisionFlag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Port relations
  a_reset_lines_idle: assert property ($rose(rst_n) |-> !sclOe && !sdaOe && clockReleaseBit)
    else $error("bus lines not idle after reset");
  a_read_clears_full: assert property (clkEn && bufferRe |=> !bufferFullFlag)
    else $error("buffer read left full flag set");
  a_release_sets_bit: assert property (clkEn && setClockRelease |=> clockReleaseBit)
    else $error("clock release bit not set");
  a_hold_when_low: assert property ($rose(sclOe) |-> !sclIn && (!clockReleaseBit || updateAddressFlag))
    else $error("clock held without cause or while high");
  a_addr_write_frees: assert property (clkEn && slaveAddressWe && clockReleaseBit |=> !updateAddressFlag ##[0:3] !sclOe)
    else $error("address write did not free the clock");
  a_ack_status_high: assert property ($changed(ackReceivedStatus) |-> sclIn)
    else $error("received ack changed while clock low");
  a_irq_on_fall: assert property ($rose(serialPortIrqFlag) |-> !sclIn)
    else $error("interrupt flag rose while clock high");
  a_data_on_low: assert property ($changed(sdaOe) |-> !sclIn || busCollisionFlag)
    else $error("data line changed while clock high");
  a_collision_frees: assert property ($rose(busCollisionFlag) |-> ##[0:4] !sdaOe)
    else $error("data line kept after collision");
  a_stop_clock_high: assert property ($rose(stopSeenFlag) |-> sclIn)
    else $error("stop flag set while clock low");
  c_irq: cover property ($rose(serialPortIrqFlag));
  c_update: cover property ($rose(updateAddressFlag));
  c_collide: cover property ($rose(busCollisionFlag));
  c_stop: cover property ($rose(stopSeenFlag));
endmodule
bind i2c_slave_hold_transmit_engine i2c_engine_chk chk (.mclk, .rst_n, .clkEn, .sclIn, .sclOe,
  .sdaOe, .bufferRe, .setClockRelease, .slaveAddressWe, .serialPortIrqFlag, .clockReleaseBit,
  .bufferFullFlag, .ackReceivedStatus, .updateAddressFlag, .stopSeenFlag, .busCollisionFlag);

/* verif/testbench.sv */
// Self-checking bench for the two-wire slave engine.
`timescale 1ns/1ps
module testbench;
  logic       mclk;
  logic       rst_n  = 1'b0;
  logic [5:0] cfg    = 6'h02;
  logic [4:0] pls    = 5'h00;
  logic [9:0] addrWr = 10'h000;
  logic       addrWe = 1'b0;
  logic [7:0] bufWr  = 8'h00;
  logic       bufWe  = 1'b0;
  logic       s;
  logic [7:0] rx;
  wire        sclOe;
  wire        sdaOe;
  wire        mSclLow;
  wire        mSdaLow;
  wire  [7:0] rxTxBuffer;
  wire  [9:0] slaveAddressReg;
  wire  [9:0] flags;
  int         failures  = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  wire        sclBus = !(mSclLow || sclOe);
  wire        sdaBus = !(mSdaLow || sdaOe);
  i2c_slave_hold_transmit_engine uut (
    .mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .sclIn(sclBus), .sclOut(), .sclOe(sclOe),
    .sdaIn(sdaBus), .sdaOut(), .sdaOe(sdaOe), .tenBitMode(cfg[5]), .addressHoldEnable(cfg[4]),
    .dataHoldEnable(cfg[3]), .stretchEnable(cfg[2]), .slaveCollisionDetectEnable(cfg[1]),
    .ackValueSelect(cfg[0]), .slaveAddressWr(addrWr), .slaveAddressWe(addrWe),
    .bufferWrData(bufWr), .bufferWe(bufWe), .bufferRe(pls[0]), .rxTxBuffer(rxTxBuffer),
    .setClockRelease(pls[1]), .clearIrqFlag(pls[2]), .clearCollisionFlag(pls[3]),
    .clearOverflowFlag(pls[4]), .serialPortIrqFlag(flags[9]), .clockReleaseBit(flags[8]),
    .ackTimeFlag(flags[7]), .bufferFullFlag(flags[6]), .receiveOverflowFlag(flags[5]),
    .ackReceivedStatus(flags[4]), .readWriteStatus(flags[3]), .updateAddressFlag(flags[2]),
    .stopSeenFlag(flags[1]), .busCollisionFlag(flags[0]), .slaveAddressReg(slaveAddressReg));
  i2c_master_model master (.mclk(mclk), .sclBus(sclBus), .sdaBus(sdaBus), .sclLow(mSclLow),
    .sdaLow(mSdaLow));
  // ==========================================================================
  // Access tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Bits: 9 irq, 8 release, 7 ack time, 6 full, 5 overflow, 4 ack in, 3 read, 2 update, 1 stop.
  task automatic flg(input logic [9:0] m, input logic [9:0] v);
    check("flags", flags & m, v);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge mclk);
    pls <= m;
    @(posedge mclk);
    pls <= 5'h00;
    @(posedge mclk);
  endtask
  task automatic wr(input logic toAddr, input logic [9:0] v);
    @(posedge mclk);
    addrWr <= v;
    bufWr <= v[7:0];
    addrWe <= toAddr;
    bufWe <= !toAddr;
    @(posedge mclk);
    addrWe <= 1'b0;
    bufWe <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic byteIo(input logic [7:0] tx, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) master.bitIo(tx[i], v[i]);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    flg(10'h3FF, 10'h100);
    wr(1'b1, 10'h0A4);
    check("addr", slaveAddressReg, 10'h0A4);
    cfg <= 6'h06;
    master.start();
    byteIo(8'hA4, rx);
    master.bitIo(1'b1, s);
    check("ack", s, 10'h000);
    flg(10'h348, 10'h240);
    check("buf", rxTxBuffer, 10'h0A4);
    check("hold", sclOe, 10'h001);
    pulse(5'h07);
    flg(10'h340, 10'h100);
    byteIo(8'h3C, rx);
    master.bitIo(1'b1, s);
    flg(10'h340, 10'h240);
    check("buf", rxTxBuffer, 10'h03C);
    cfg <= 6'h02;
    pulse(5'h06);
    master.stop();
    flg(10'h002, 10'h002);
    master.start();
    byteIo(8'hA4, rx);
    master.bitIo(1'b1, s);
    check("ack", s, 10'h001);
    flg(10'h220, 10'h020);
    master.stop();
    pulse(5'h15);
    cfg <= 6'h1A;
    master.start();
    byteIo(8'hA4, rx);
    flg(10'h380, 10'h280);
    check("hold", sclOe, 10'h001);
    pulse(5'h07);
    master.bitIo(1'b1, s);
    check("ack", s, 10'h000);
    flg(10'h280, 10'h200);
    pulse(5'h05);
    byteIo(8'h96, rx);
    flg(10'h380, 10'h280);
    cfg <= 6'h1B;
    pulse(5'h07);
    master.bitIo(1'b1, s);
    check("ack", s, 10'h001);
    flg(10'h200, 10'h000);
    master.stop();
    cfg <= 6'h02;
    master.start();
    byteIo(8'hA5, rx);
    master.bitIo(1'b1, s);
    check("ack", s, 10'h000);
    flg(10'h348, 10'h248);
    check("buf", rxTxBuffer, 10'h0A5);
    check("hold", sclOe, 10'h001);
    pulse(5'h05);
    wr(1'b0, 10'h0C3);
    pulse(5'h02);
    byteIo(8'hFF, rx);
    check("tx", rx, 10'h0C3);
    master.bitIo(1'b0, s);
    flg(10'h310, 10'h200);
    check("hold", sclOe, 10'h001);
    pulse(5'h05);
    wr(1'b0, 10'h05A);
    pulse(5'h02);
    byteIo(8'hFF, rx);
    check("tx", rx, 10'h05A);
    master.bitIo(1'b1, s);
    flg(10'h210, 10'h210);
    check("hold", sclOe, 10'h000);
    master.stop();
    pulse(5'h05);
    master.start();
    byteIo(8'hA5, rx);
    master.bitIo(1'b1, s);
    pulse(5'h05);
    wr(1'b0, 10'h080);
    pulse(5'h02);
    master.bitIo(1'b0, s);
    flg(10'h001, 10'h001);
    check("sdaOe", sdaOe, 10'h000);
    master.stop();
    pulse(5'h0D);
    cfg <= 6'h22;
    wr(1'b1, 10'h2B4);
    master.start();
    byteIo(8'hF4, rx);
    master.bitIo(1'b1, s);
    check("ack", s, 10'h000);
    flg(10'h204, 10'h204);
    check("hold", sclOe, 10'h001);
    pulse(5'h05);
    wr(1'b1, 10'h2B4);
    flg(10'h004, 10'h000);
    check("hold", sclOe, 10'h000);
    byteIo(8'h00, rx);
    master.bitIo(1'b1, s);
    flg(10'h344, 10'h304);
    wr(1'b1, 10'h2B4);
    master.stop();
    print_verdict();
  end
endmodule
